// >>> common/iod_pkg.sv
// Summary of operation
// - Single-bit set and clear are accepted only for I/O addresses 0x00 to 0x1F.
// - Skip-if-bit-set and skip-if-bit-clear test one bit in that same low range.
// - Flag bits clear when written with one; writing zero leaves them unchanged.
// - Single-bit set or clear changes only the addressed bit, never others.
// - Short I/O read and write use I/O addresses 0x00 through 0x3F.
// - Data-space address of an I/O register is its I/O address plus 0x20.
// - Short I/O operations carry a six-bit address covering 64 locations only.
// - Extended area 0x60 to 0xFF is reachable only by data-space load and store.
package iod_pkg;

  // ==========================================================================
  // Address space
  localparam int unsigned IO_SIZE        = 64;
  localparam logic [7:0]  BIT_OP_LIMIT   = 8'h1F;
  localparam logic [7:0]  SHORT_IO_LIMIT = 8'h3F;
  localparam logic [7:0]  DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0]  EXT_IO_FIRST   = 8'h60;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // ==========================================================================
  // Register offsets in I/O space
  localparam logic [5:0] PORT_A_PIN_INPUT  = 6'h00;
  localparam logic [5:0] PORT_A_DIRECTION  = 6'h01;
  localparam logic [5:0] PORT_A_OUTPUT     = 6'h02;
  localparam logic [5:0] PORT_B_PIN_INPUT  = 6'h03;
  localparam logic [5:0] PORT_B_DIRECTION  = 6'h04;
  localparam logic [5:0] PORT_B_OUTPUT     = 6'h05;
  localparam logic [5:0] PORT_C_PIN_INPUT  = 6'h06;
  localparam logic [5:0] PORT_C_DIRECTION  = 6'h07;
  localparam logic [5:0] PORT_C_OUTPUT     = 6'h08;
  localparam logic [5:0] PORT_D_PIN_INPUT  = 6'h09;
  localparam logic [5:0] PORT_D_DIRECTION  = 6'h0A;
  localparam logic [5:0] PORT_D_OUTPUT     = 6'h0B;
  localparam logic [5:0] PORT_E_PIN_INPUT  = 6'h0C;
  localparam logic [5:0] PORT_E_DIRECTION  = 6'h0D;
  localparam logic [5:0] PORT_E_OUTPUT     = 6'h0E;
  localparam logic [5:0] PORT_F_PIN_INPUT  = 6'h0F;
  localparam logic [5:0] PORT_F_DIRECTION  = 6'h10;
  localparam logic [5:0] PORT_F_OUTPUT     = 6'h11;
  localparam logic [5:0] PORT_G_PIN_INPUT  = 6'h12;
  localparam logic [5:0] PORT_G_DIRECTION  = 6'h13;
  localparam logic [5:0] PORT_G_OUTPUT     = 6'h14;
  localparam logic [5:0] TIMER_ZERO_FLAGS  = 6'h15;
  localparam logic [5:0] TIMER_ONE_FLAGS   = 6'h16;
  localparam logic [5:0] TIMER_TWO_FLAGS   = 6'h17;
  localparam logic [5:0] TIMER_ZERO_CONTROL = 6'h24;
  localparam logic [5:0] TIMER_ZERO_COUNT  = 6'h26;
  localparam logic [5:0] TIMER_ZERO_COMPARE = 6'h27;
  localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h30;
  localparam logic [5:0] DEBUG_DATA_CHANNEL = 6'h31;
  localparam logic [5:0] SLEEP_CONTROL     = 6'h33;

  // ==========================================================================
  // Field layouts
  localparam logic [7:0] FULL_MASK        = 8'hFF;
  localparam logic [7:0] PORT_G_OUT_MASK  = 8'h1F;
  localparam logic [7:0] PORT_G_PIN_MASK  = 8'h3F;
  localparam logic [7:0] TIMER_ZERO_FLAG_MASK = 8'h03;
  localparam logic [7:0] TIMER_ONE_FLAG_MASK  = 8'h27;
  localparam logic [7:0] TIMER_TWO_FLAG_MASK  = 8'h03;
  localparam logic [7:0] TIMER_ZERO_CTRL_MASK = 8'h7F;
  localparam logic [7:0] FORCE_COMPARE_MASK   = 8'h80;
  localparam logic [7:0] COMPARATOR_RW_MASK   = 8'hCF;
  localparam logic [7:0] COMPARATOR_OUT_MASK  = 8'h20;
  localparam logic [7:0] COMPARATOR_FLAG_MASK = 8'h10;
  localparam logic [7:0] SLEEP_MASK           = 8'h0F;

  // ==========================================================================
  // Core operations
  typedef enum logic [2:0] {
    IOD_IO_READ,
    IOD_IO_WRITE,
    IOD_IO_BIT_SET,
    IOD_IO_BIT_CLEAR,
    IOD_SKIP_IF_IO_BIT_SET,
    IOD_SKIP_IF_IO_BIT_CLEAR,
    IOD_MEMORY_READ_OP,
    IOD_MEMORY_WRITE_OP
  } iod_op_t;

  // Software-writable, write-one-to-clear, hardware-driven and strobe bits.
  typedef struct packed {
    logic [7:0] rw;
    logic [7:0] w1c;
    logic [7:0] hw;
    logic [7:0] stb;
  } iod_mask_t;

  function automatic iod_mask_t iod_masks(input logic [5:0] idx);
    iod_mask_t m;
    m = '0;
    unique case (idx)
      PORT_A_PIN_INPUT, PORT_B_PIN_INPUT, PORT_C_PIN_INPUT, PORT_D_PIN_INPUT,
      PORT_E_PIN_INPUT, PORT_F_PIN_INPUT: m.hw = FULL_MASK;
      PORT_G_PIN_INPUT: m.hw = PORT_G_PIN_MASK;
      PORT_A_DIRECTION, PORT_A_OUTPUT, PORT_B_DIRECTION, PORT_B_OUTPUT,
      PORT_C_DIRECTION, PORT_C_OUTPUT, PORT_D_DIRECTION, PORT_D_OUTPUT,
      PORT_E_DIRECTION, PORT_E_OUTPUT, PORT_F_DIRECTION, PORT_F_OUTPUT,
      TIMER_ZERO_COUNT, TIMER_ZERO_COMPARE, DEBUG_DATA_CHANNEL: m.rw = FULL_MASK;
      PORT_G_DIRECTION, PORT_G_OUTPUT: m.rw = PORT_G_OUT_MASK;
      TIMER_ZERO_FLAGS: m.w1c = TIMER_ZERO_FLAG_MASK;
      TIMER_ONE_FLAGS: m.w1c = TIMER_ONE_FLAG_MASK;
      TIMER_TWO_FLAGS: m.w1c = TIMER_TWO_FLAG_MASK;
      TIMER_ZERO_CONTROL:
      begin
        m.rw  = TIMER_ZERO_CTRL_MASK;
        m.stb = FORCE_COMPARE_MASK;
      end
      COMPARATOR_CONTROL_STATUS:
      begin
        m.rw  = COMPARATOR_RW_MASK;
        m.hw  = COMPARATOR_OUT_MASK;
        m.w1c = COMPARATOR_FLAG_MASK;
      end
      SLEEP_CONTROL: m.rw = SLEEP_MASK;
      default: m = '0;
    endcase
    return m;
  endfunction

endpackage

// >>> hw/iod_io_space_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module iod_io_space_decoder
  import iod_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Core request
  input  wire logic       req_valid,
  input  wire iod_op_t    req_op,
  input  wire logic [7:0] req_addr,
  input  wire logic [2:0] req_bit,
  input  wire logic [7:0] req_wdata,
  // Core answer
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_skip,
  output logic            rsp_refused,
  // Port pins
  input  wire logic [7:0] port_a_pin,
  input  wire logic [7:0] port_b_pin,
  input  wire logic [7:0] port_c_pin,
  input  wire logic [7:0] port_d_pin,
  input  wire logic [7:0] port_e_pin,
  input  wire logic [7:0] port_f_pin,
  input  wire logic [7:0] port_g_pin,
  // Port drivers
  output logic [7:0]      port_a_dir,
  output logic [7:0]      port_a_out,
  output logic [7:0]      port_b_dir,
  output logic [7:0]      port_b_out,
  output logic [7:0]      port_c_dir,
  output logic [7:0]      port_c_out,
  output logic [7:0]      port_d_dir,
  output logic [7:0]      port_d_out,
  output logic [7:0]      port_e_dir,
  output logic [7:0]      port_e_out,
  output logic [7:0]      port_f_dir,
  output logic [7:0]      port_f_out,
  output logic [7:0]      port_g_dir,
  output logic [7:0]      port_g_out,
  // Peripheral events and levels
  input  wire logic [7:0] timer_zero_flag_set,
  input  wire logic [7:0] timer_one_flag_set,
  input  wire logic [7:0] timer_two_flag_set,
  input  wire logic       comparator_flag_set,
  input  wire logic       comparator_level,
  // Peripheral settings
  output logic [7:0]      timer_zero_ctrl,
  output logic            timer_zero_force,
  output logic [7:0]      timer_zero_count,
  output logic [7:0]      timer_zero_compare,
  output logic [7:0]      comparator_ctrl,
  output logic [7:0]      debug_data,
  output logic [7:0]      sleep_ctrl
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [IO_SIZE-1:0][7:0] regs;
    logic                    rsp_valid;
    logic [7:0]              rsp_rdata;
    logic                    rsp_skip;
    logic                    rsp_refused;
    logic                    force_pulse;
  } iod_state_t;

  iod_state_t st;
  iod_state_t next_st;

  // ==========================================================================
  // Decode and access
  always_comb
  begin
    logic       hit;
    logic       ext;
    logic [5:0] idx;
    logic [7:0] data_idx;
    logic [7:0] cur;
    logic [7:0] readable;
    logic [7:0] bit_sel;
    iod_mask_t  m;

    hit      = 1'b0;
    ext      = 1'b0;
    idx      = 6'h00;
    data_idx = 8'h00;
    next_st  = st;
    next_st.rsp_valid   = 1'b0;
    next_st.rsp_rdata   = 8'h00;
    next_st.rsp_skip    = 1'b0;
    next_st.rsp_refused = 1'b0;
    next_st.force_pulse = 1'b0;

    unique case (req_op)
      IOD_IO_READ, IOD_IO_WRITE:
      begin
        hit = (req_addr <= SHORT_IO_LIMIT);
        idx = req_addr[5:0];
      end
      IOD_IO_BIT_SET, IOD_IO_BIT_CLEAR, IOD_SKIP_IF_IO_BIT_SET, IOD_SKIP_IF_IO_BIT_CLEAR:
      begin
        hit = (req_addr <= BIT_OP_LIMIT);
        idx = req_addr[5:0];
      end
      IOD_MEMORY_READ_OP, IOD_MEMORY_WRITE_OP:
      begin
        data_idx = req_addr - DATA_IO_OFFSET;
        ext      = (req_addr >= EXT_IO_FIRST);
        hit      = !ext && (req_addr >= DATA_IO_OFFSET);
        idx      = data_idx[5:0];
      end
    endcase

    m        = iod_masks(idx);
    cur      = st.regs[idx];
    readable = cur & (m.rw | m.w1c | m.hw);
    bit_sel  = 8'h01 << req_bit;

    if (req_valid)
    begin
      next_st.rsp_valid   = 1'b1;
      next_st.rsp_refused = !hit && !ext;
      if (hit)
      begin
        unique case (req_op)
          IOD_IO_READ, IOD_MEMORY_READ_OP:
          begin
            next_st.rsp_rdata = readable;
          end
          IOD_IO_WRITE, IOD_MEMORY_WRITE_OP:
          begin
            // Only software-writable bits take data; flags clear on one.
            next_st.regs[idx] = (cur & ~m.rw & ~(req_wdata & m.w1c)) | (req_wdata & m.rw);
            next_st.force_pulse = |(req_wdata & m.stb);
          end
          IOD_IO_BIT_SET:
          begin
            next_st.regs[idx] = (cur | (bit_sel & m.rw)) & ~(bit_sel & m.w1c);
            next_st.force_pulse = |(bit_sel & m.stb);
          end
          IOD_IO_BIT_CLEAR:
          begin
            next_st.regs[idx] = cur & ~(bit_sel & m.rw);
          end
          IOD_SKIP_IF_IO_BIT_SET:
          begin
            next_st.rsp_skip = |(readable & bit_sel);
          end
          IOD_SKIP_IF_IO_BIT_CLEAR:
          begin
            next_st.rsp_skip = ~|(readable & bit_sel);
          end
        endcase
      end
    end

    // Hardware updates come last so an event in a clearing cycle wins.
    next_st.regs[PORT_A_PIN_INPUT] = port_a_pin;
    next_st.regs[PORT_B_PIN_INPUT] = port_b_pin;
    next_st.regs[PORT_C_PIN_INPUT] = port_c_pin;
    next_st.regs[PORT_D_PIN_INPUT] = port_d_pin;
    next_st.regs[PORT_E_PIN_INPUT] = port_e_pin;
    next_st.regs[PORT_F_PIN_INPUT] = port_f_pin;
    next_st.regs[PORT_G_PIN_INPUT] = port_g_pin & PORT_G_PIN_MASK;
    next_st.regs[TIMER_ZERO_FLAGS] = next_st.regs[TIMER_ZERO_FLAGS]
                                   | (timer_zero_flag_set & TIMER_ZERO_FLAG_MASK);
    next_st.regs[TIMER_ONE_FLAGS]  = next_st.regs[TIMER_ONE_FLAGS]
                                   | (timer_one_flag_set & TIMER_ONE_FLAG_MASK);
    next_st.regs[TIMER_TWO_FLAGS]  = next_st.regs[TIMER_TWO_FLAGS]
                                   | (timer_two_flag_set & TIMER_TWO_FLAG_MASK);
    next_st.regs[COMPARATOR_CONTROL_STATUS] = (next_st.regs[COMPARATOR_CONTROL_STATUS] & ~COMPARATOR_OUT_MASK)
                                            | ({8{comparator_level}} & COMPARATOR_OUT_MASK)
                                            | ({8{comparator_flag_set}} & COMPARATOR_FLAG_MASK);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign rsp_valid          = st.rsp_valid;
  assign rsp_rdata          = st.rsp_rdata;
  assign rsp_skip           = st.rsp_skip;
  assign rsp_refused        = st.rsp_refused;
  assign port_a_dir         = st.regs[PORT_A_DIRECTION];
  assign port_a_out         = st.regs[PORT_A_OUTPUT];
  assign port_b_dir         = st.regs[PORT_B_DIRECTION];
  assign port_b_out         = st.regs[PORT_B_OUTPUT];
  assign port_c_dir         = st.regs[PORT_C_DIRECTION];
  assign port_c_out         = st.regs[PORT_C_OUTPUT];
  assign port_d_dir         = st.regs[PORT_D_DIRECTION];
  assign port_d_out         = st.regs[PORT_D_OUTPUT];
  assign port_e_dir         = st.regs[PORT_E_DIRECTION];
  assign port_e_out         = st.regs[PORT_E_OUTPUT];
  assign port_f_dir         = st.regs[PORT_F_DIRECTION];
  assign port_f_out         = st.regs[PORT_F_OUTPUT];
  assign port_g_dir         = st.regs[PORT_G_DIRECTION];
  assign port_g_out         = st.regs[PORT_G_OUTPUT];
  assign timer_zero_ctrl    = st.regs[TIMER_ZERO_CONTROL];
  assign timer_zero_force   = st.force_pulse;
  assign timer_zero_count   = st.regs[TIMER_ZERO_COUNT];
  assign timer_zero_compare = st.regs[TIMER_ZERO_COMPARE];
  assign comparator_ctrl    = st.regs[COMPARATOR_CONTROL_STATUS];
  assign debug_data         = st.regs[DEBUG_DATA_CHANNEL];
  assign sleep_ctrl         = st.regs[SLEEP_CONTROL];

endmodule // iod_io_space_decoder

`default_nettype wire

// >>> verif/iod_io_space_decoder_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Request and answer checks
module iod_io_space_decoder_assertions
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Request
  input wire logic       req_valid,
  input wire iod_op_t    req_op,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_bit,
  // Answer and port A output
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic       rsp_skip,
  input wire logic       rsp_refused,
  input wire logic [7:0] port_a_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic bit_op, skip_op, short_op;
  assign bit_op = req_valid && (req_op == IOD_IO_BIT_SET || req_op == IOD_IO_BIT_CLEAR);
  assign skip_op = req_valid && (req_op == IOD_SKIP_IF_IO_BIT_SET || req_op == IOD_SKIP_IF_IO_BIT_CLEAR);
  assign short_op = req_valid && (req_op == IOD_IO_READ || req_op == IOD_IO_WRITE);
  a_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("answer not one cycle after request");
  a_answer_none: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_bit_range: assert property (bit_op && req_addr > 8'h1F |=> rsp_refused)
    else $error("bit op above low range taken");
  a_skip_range: assert property (skip_op && req_addr <= 8'h1F |=> !rsp_refused)
    else $error("skip op in low range refused");
  a_short_range: assert property (short_op && req_addr > 8'h3F |=> rsp_refused && rsp_rdata == 8'h00)
    else $error("short op above 64 locations taken");
  a_short_ok: assert property (short_op && req_addr <= 8'h3F |=> rsp_valid && !rsp_refused)
    else $error("short op in range refused");
  a_data_offset: assert property (req_valid && req_op == IOD_MEMORY_READ_OP && req_addr == 8'h22
    |=> rsp_rdata == $past(port_a_out))
    else $error("data address of output register wrong");
  a_ext_area: assert property (req_valid && req_op == IOD_MEMORY_READ_OP && req_addr >= 8'h60
    |=> !rsp_refused && rsp_rdata == 8'h00)
    else $error("extended area load wrong");
  a_skip_value: assert property (req_valid && req_op == IOD_SKIP_IF_IO_BIT_SET && req_addr == 8'h02
    |=> rsp_skip == $past(port_a_out[req_bit]))
    else $error("skip result wrong");
  a_bit_only: assert property (req_valid && req_op == IOD_IO_BIT_SET && req_addr == 8'h02
    |=> port_a_out == ($past(port_a_out) | (8'h01 << $past(req_bit))))
    else $error("bit set touched other bits");
endmodule // iod_io_space_decoder_assertions
bind iod_io_space_decoder iod_io_space_decoder_assertions chk_u (.clk_sys, .resetn, .req_valid, .req_op,
  .req_addr, .req_bit, .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_refused, .port_a_out);
`default_nettype wire

// >>> verif/iod_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Core side: issues one request and takes its answer
module iod_core_model
  import iod_pkg::*;
(
  input  wire logic       clk_sys,
  output logic            req_valid,
  output iod_op_t         req_op,
  output logic [7:0]      req_addr,
  output logic [2:0]      req_bit,
  output logic [7:0]      req_wdata,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata,
  input  wire logic       rsp_skip,
  input  wire logic       rsp_refused
);
  initial
  begin
    req_valid = 1'b0;
    req_op = IOD_IO_READ;
    req_addr = 8'h00;
    req_bit = 3'h0;
    req_wdata = 8'h00;
  end
  task automatic access(input iod_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
                        output logic [7:0] rd, output logic sk, output logic rf);
    @(posedge clk_sys);
    #2;
    req_valid = 1'b1;
    {req_op, req_addr, req_bit, req_wdata} = {op, a, b, d};
    @(posedge clk_sys);
    #2;
    req_valid = 1'b0;
    req_wdata = ~d;
    rd = rsp_valid ? rsp_rdata : 8'hEE;
    {sk, rf} = {rsp_skip, rsp_refused};
  endtask
endmodule // iod_core_model
`default_nettype wire

// >>> verif/iod_io_space_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module iod_io_space_decoder_tb;
  import iod_pkg::*;
  logic clk_sys, resetn, req_valid, rsp_valid, rsp_skip, rsp_refused, sk, rf;
  iod_op_t req_op;
  logic [7:0] req_addr, req_wdata, rsp_rdata, pin_v, tz_set, cmp, rd, tzc;
  logic [2:0] req_bit;
  logic [7:0] dir [7];
  logic [7:0] out [7];
  int bad_count = 0;
  int checked = 0;
  iod_io_space_decoder dut_u (.clk_sys, .resetn, .req_valid, .req_op, .req_addr, .req_bit, .req_wdata,
    .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_refused, .port_a_pin(pin_v), .port_b_pin(pin_v ^ 8'h01),
    .port_c_pin(pin_v ^ 8'h02), .port_d_pin(pin_v ^ 8'h03), .port_e_pin(pin_v ^ 8'h04),
    .port_f_pin(pin_v ^ 8'h05), .port_g_pin(pin_v), .port_a_dir(dir[0]), .port_a_out(out[0]),
    .port_b_dir(dir[1]), .port_b_out(out[1]), .port_c_dir(dir[2]), .port_c_out(out[2]),
    .port_d_dir(dir[3]), .port_d_out(out[3]), .port_e_dir(dir[4]), .port_e_out(out[4]),
    .port_f_dir(dir[5]), .port_f_out(out[5]), .port_g_dir(dir[6]), .port_g_out(out[6]),
    .timer_zero_flag_set(tz_set), .timer_one_flag_set(8'h00), .timer_two_flag_set(8'h00),
    .comparator_flag_set(1'b0), .comparator_level(1'b0), .timer_zero_ctrl(tzc), .timer_zero_force(),
    .timer_zero_count(), .timer_zero_compare(cmp), .comparator_ctrl(), .debug_data(), .sleep_ctrl());
  iod_core_model core_u (.clk_sys, .req_valid, .req_op, .req_addr, .req_bit, .req_wdata,
    .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_refused);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input iod_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    core_u.access(op, a, b, d, rd, sk, rf);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic test_ports();
    for (int i = 0; i < 6; i++)
    begin
      acc(IOD_IO_WRITE, 8'(3 * i + 1), 3'h0, 8'(16 * i + 3));
      acc(IOD_IO_WRITE, 8'(3 * i + 2), 3'h0, 8'(~(16 * i + 3)));
      chk("dir", 8'(16 * i + 3), dir[i]);
      chk("out", 8'(~(16 * i + 3)), out[i]);
      acc(IOD_MEMORY_READ_OP, 8'(3 * i + 33), 3'h0, 8'h00);
      chk("data dir", 8'(16 * i + 3), rd);
      acc(IOD_MEMORY_READ_OP, 8'(3 * i + 34), 3'h0, 8'h00);
      chk("data out", 8'(~(16 * i + 3)), rd);
      acc(IOD_IO_READ, 8'(3 * i), 3'h0, 8'h00);
      chk("pin", pin_v ^ 8'(i), rd);
    end
    $display("test_ports done");
  endtask
  task automatic test_bits();
    acc(IOD_IO_WRITE, 8'h02, 3'h0, 8'h81);
    acc(IOD_IO_BIT_SET, 8'h02, 3'h3, 8'h00);
    chk("bit set", 8'h89, out[0]);
    acc(IOD_IO_BIT_CLEAR, 8'h02, 3'h7, 8'h00);
    chk("bit clear", 8'h09, out[0]);
    acc(IOD_SKIP_IF_IO_BIT_SET, 8'h02, 3'h3, 8'h00);
    chk("skip set", 8'h01, sk);
    acc(IOD_SKIP_IF_IO_BIT_CLEAR, 8'h02, 3'h3, 8'h00);
    chk("skip clear", 8'h00, sk);
    acc(IOD_SKIP_IF_IO_BIT_SET, 8'h20, 3'h0, 8'h00);
    chk("skip refused", 8'h01, rf);
    acc(IOD_IO_WRITE, 8'h27, 3'h0, 8'h40);
    acc(IOD_IO_BIT_SET, 8'h27, 3'h0, 8'h00);
    chk("bit refused", 8'h01, rf);
    chk("compare kept", 8'h40, cmp);
    $display("test_bits done");
  endtask
  task automatic test_flags();
    @(posedge clk_sys);
    #2 tz_set = 8'hFF;
    @(posedge clk_sys);
    #2 tz_set = 8'h00;
    acc(IOD_IO_READ, 8'h15, 3'h0, 8'h00);
    chk("flags", 8'h03, rd);
    acc(IOD_IO_BIT_SET, 8'h15, 3'h0, 8'h00);
    acc(IOD_IO_READ, 8'h15, 3'h0, 8'h00);
    chk("flag bit", 8'h02, rd);
    acc(IOD_IO_WRITE, 8'h15, 3'h0, 8'h00);
    acc(IOD_IO_READ, 8'h15, 3'h0, 8'h00);
    chk("flag zero", 8'h02, rd);
    acc(IOD_IO_WRITE, 8'h15, 3'h0, 8'h02);
    acc(IOD_IO_READ, 8'h15, 3'h0, 8'h00);
    chk("flag one", 8'h00, rd);
    $display("test_flags done");
  endtask
  task automatic test_limits();
    acc(IOD_IO_READ, 8'h40, 3'h0, 8'h00);
    chk("short refused", 8'h01, rf);
    acc(IOD_IO_READ, 8'h3F, 3'h0, 8'h00);
    chk("top taken", 8'h00, rf);
    acc(IOD_MEMORY_WRITE_OP, 8'h47, 3'h0, 8'h6C);
    chk("data store", 8'h6C, cmp);
    acc(IOD_MEMORY_READ_OP, 8'h60, 3'h0, 8'h00);
    chk("ext taken", 8'h00, rf);
    acc(IOD_MEMORY_READ_OP, 8'hFF, 3'h0, 8'h00);
    chk("ext read", 8'h00, rd);
    acc(IOD_IO_READ, 8'h25, 3'h0, 8'h00);
    chk("reserved", 8'h00, rd);
    acc(IOD_IO_WRITE, 8'h24, 3'h0, 8'hFF);
    chk("ctrl reserved bit", 8'h7F, tzc);
    $display("test_limits done");
  endtask
  initial
  begin
    resetn = 1'b0;
    pin_v = 8'hA6;
    tz_set = 8'h00;
    repeat (16) @(posedge clk_sys);
    #2 resetn = 1'b1;
    test_ports();
    test_bits();
    test_flags();
    test_limits();
    results();
  end
  initial
  begin
    #100us;
    bad_count++;
    results();
  end
endmodule // iod_io_space_decoder_tb
`default_nettype wire
